// [hdl/ssio_defines.svh]
// Purpose: offsets, field positions and reset values of the serial port
// Assumes: 32-bit word registers on an AHB-Lite slave
// Notes: definitions only
`ifndef SSIO_DEFINES_SVH
`define SSIO_DEFINES_SVH
// register byte offsets
`define SSIO_CTRL_OFS 8'h00
`define SSIO_BUF_OFS 8'h04
`define SSIO_STAT_OFS 8'h20
// control field positions
`define SSIO_CTRL_RUN 7
`define SSIO_CTRL_EDGE 6
`define SSIO_CTRL_CKS_HI 5
`define SSIO_CTRL_CKS_LO 3
`define SSIO_CTRL_DIR 2
// status field positions
`define SSIO_ST_ACTIVE 7
`define SSIO_ST_SHIFT 6
`define SSIO_ST_OVR 5
`define SSIO_ST_RXDONE 4
`define SSIO_ST_UNDR 3
`define SSIO_ST_TXPEND 2
// reset values and constants
`define SSIO_CTRL_RST 8'h00
`define SSIO_STAT_RST 8'h00
`define SSIO_CKS_EXT 3'h7
`define SSIO_BITS 4'h8
`endif

// [hdl/ssio_pkg.sv]
// Purpose: types shared by the serial port
// Assumes: field layout from ssio_defines.svh
// Notes: no constants of timing here
package ssio_pkg;
   // transfer mode codes
   typedef enum logic [1:0] {SSIO_OFF = 2'h0, SSIO_TX = 2'h1, SSIO_RX = 2'h2,
      SSIO_TXRX = 2'h3} ssio_mode_t;
   // control register image
   typedef struct packed {
      logic run;
      logic edgeSel;
      logic [2:0] clkSel;
      logic bitOrder;
      ssio_mode_t mode;
   } ssio_ctrl_t;
   // whole state of the block
   typedef struct packed {
      logic [1:0] ckSync;
      logic ckPrev;
      logic [1:0] inSync;
      logic wrPend;
      logic [7:0] wAddr;
      ssio_ctrl_t ctrl;
      logic [7:0] dataBuf;
      logic [7:0] shReg;
      logic [3:0] bitCnt;
      logic launched;
      logic active;
      logic shifting;
      logic txPending;
      logic rxDone;
      logic overrun;
      logic underrun;
      logic stopReq;
      logic sclk;
      logic [8:0] divCnt;
      logic serialOut;
      logic irq;
      logic [31:0] rdata;
   } ssio_state_t;
endpackage

// [hdl/ssio_top.sv]
// Purpose: clocked serial port, 8-bit transmit and 8-bit receive modes
// Assumes: clk 20 MHz, sys_rst synchronous active high, AHB-Lite slave
// Notes: the link clock pin is sampled by clk, so it must be slow
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ns
`include "ssio_defines.svh"

module ssio_top
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // serial pins
   input wire logic serialClockIn,
   output logic serialClockOut,
   output logic serialClockOe,
   output logic serialOut,
   input wire logic serialIn,
   // event output
   output logic serialIrq
);

   ssio_pkg::ssio_state_t q, d;
   logic addrOk, wrCtrl, wrBuf, rdBuf, rdStat, extClk, txMode, rxMode;
   logic rise, fall, launchEv, sampleEv, byteDone, idleLvl;
   logic [8:0] half;
   logic [7:0] statusImg, txBit;
   ssio_pkg::ssio_ctrl_t newCtrl;

   // ***************************************************************
   // bus decode and edge events
   // ***************************************************************

   // accepted address phase; writes act in the data phase
   assign addrOk = hsel & hready & htrans[1];
   assign wrCtrl = q.wrPend & (q.wAddr == `SSIO_CTRL_OFS);
   assign wrBuf = q.wrPend & (q.wAddr == `SSIO_BUF_OFS);
   assign rdBuf = addrOk & ~hwrite & (haddr[7:0] == `SSIO_BUF_OFS);
   assign rdStat = addrOk & ~hwrite & (haddr[7:0] == `SSIO_STAT_OFS);
   assign newCtrl = ssio_pkg::ssio_ctrl_t'(hwdata[7:0]);
   assign extClk = (q.ctrl.clkSel == `SSIO_CKS_EXT);
   assign txMode = (q.ctrl.mode == ssio_pkg::SSIO_TX);
   assign rxMode = (q.ctrl.mode == ssio_pkg::SSIO_RX);
   // idle level chosen so the first edge out of idle is a launch edge
   assign idleLvl = ~q.ctrl.edgeSel;
   // half period in clk cycles: 2^8 for code 0, else 2^(6-code)
   assign half = 9'(9'h001 << ((q.ctrl.clkSel == 3'h0) ? 4'h8 :
      4'(3'h6 - q.ctrl.clkSel)));

   // edges of the shift clock, internal toggle or synchronised pin
   always_comb
   begin
      if (extClk)
      begin
         rise = q.ckSync[1] & ~q.ckPrev;
         fall = ~q.ckSync[1] & q.ckPrev;
      end
      else
      begin
         rise = q.active & q.shifting & (q.divCnt == half - 9'h001) & ~q.sclk;
         fall = q.active & q.shifting & (q.divCnt == half - 9'h001) & q.sclk;
      end
   end

   assign launchEv = q.active & (txMode | rxMode) & (q.ctrl.edgeSel ? rise : fall);
   assign sampleEv = q.active & (txMode | rxMode) & (q.ctrl.edgeSel ? fall : rise);
   // a byte ends on its eighth counted sample edge
   assign byteDone = sampleEv & q.shifting & q.launched
      & (q.bitCnt == `SSIO_BITS - 4'h1);
   assign txBit = q.ctrl.bitOrder ? {7'h00, q.shReg[7]} : {7'h00, q.shReg[0]};

   // status image, low two bits read as zero
   assign statusImg = {q.active, q.shifting, q.overrun, q.rxDone, q.underrun,
      q.txPending, 2'h0};

   // ***************************************************************
   // next-state logic
   // ***************************************************************

   // order matters: read clears first, hardware sets after so sets win; a forced stop comes after both, then the buffer write
   always_comb
   begin
      d = q;
      d.irq = 1'b0;
      d.ckSync = {q.ckSync[0], serialClockIn};
      d.ckPrev = q.ckSync[1];
      d.inSync = {q.inSync[0], serialIn};
      d.wrPend = addrOk & hwrite;
      d.wAddr = haddr[7:0];
      // read data registered in the address phase, unmapped reads zero
      d.rdata = 32'h0000_0000;
      if (addrOk & ~hwrite)
      begin
         unique case (haddr[7:0])
            `SSIO_CTRL_OFS: d.rdata = {24'h000000, q.ctrl};
            `SSIO_BUF_OFS: d.rdata = {24'h000000, q.dataBuf};
            `SSIO_STAT_OFS: d.rdata = {24'h000000, statusImg};
            default: d.rdata = 32'h0000_0000;
         endcase
      end

      // read side effects
      if (rdBuf)
      begin
         d.rxDone = 1'b0;
         // internal receive resumes once the buffer is read
         if (rxMode & q.active & ~q.shifting & ~extClk)
         begin
            d.shifting = 1'b1;
            d.bitCnt = 4'h0;
            d.launched = 1'b0;
         end
      end
      if (rdStat)
      begin
         d.overrun = 1'b0;
         d.underrun = 1'b0;
      end

      // internal clock divider, runs only while shifting
      if (~extClk & q.active & q.shifting)
      begin
         if (q.divCnt == half - 9'h001)
         begin
            d.divCnt = 9'h000;
            d.sclk = ~q.sclk;
         end
         else
            d.divCnt = q.divCnt + 9'h001;
      end

      // launch edge: next transmit bit goes out
      if (launchEv)
      begin
         if (q.shifting)
         begin
            d.launched = 1'b1;
            if (txMode)
            begin
               d.serialOut = txBit[0];
               d.shReg = q.ctrl.bitOrder ? {q.shReg[6:0], 1'b0} : {1'b0, q.shReg[7:1]};
            end
         end
         else if (txMode & extClk & ~q.stopReq)
         begin
            // clock with nothing loaded: stale contents go out as junk
            d.underrun = 1'b1;
            d.shifting = 1'b1;
            d.launched = 1'b1;
            d.bitCnt = 4'h0;
            d.serialOut = txBit[0];
            d.shReg = q.ctrl.bitOrder ? {q.shReg[6:0], 1'b0} : {1'b0, q.shReg[7:1]};
         end
      end

      // sample edge: count the bit, shift input in when receiving
      if (sampleEv & q.shifting & q.launched)
      begin
         d.bitCnt = q.bitCnt + 4'h1;
         if (rxMode)
            d.shReg = q.ctrl.bitOrder ? {q.shReg[6:0], q.inSync[1]} :
               {q.inSync[1], q.shReg[7:1]};
      end

      // end of byte
      if (byteDone)
      begin
         d.bitCnt = 4'h0;
         d.launched = 1'b0;
         if (txMode)
         begin
            if (q.stopReq)
            begin
               // reserved stop: pending byte is dropped
               d.active = 1'b0;
               d.shifting = 1'b0;
               d.txPending = 1'b0;
               d.stopReq = 1'b0;
               d.irq = 1'b1;
               if (~extClk)
                  d.serialOut = 1'b1;
            end
            else if (q.txPending)
            begin
               d.shReg = q.dataBuf;
               d.txPending = 1'b0;
               d.irq = 1'b1;
            end
            else
            begin
               d.shifting = 1'b0;
               if (~extClk)
                  d.serialOut = 1'b1;
            end
         end
         else
         begin
            d.irq = 1'b1;
            if (q.rxDone & extClk)
               d.overrun = 1'b1;
            else
            begin
               d.dataBuf = d.shReg;
               d.rxDone = 1'b1;
            end
            if (q.stopReq)
            begin
               d.active = 1'b0;
               d.shifting = 1'b0;
               d.stopReq = 1'b0;
            end
            else if (~extClk)
               d.shifting = 1'b0;
         end
      end

      // control register write
      if (wrCtrl)
      begin
         if (newCtrl.mode == ssio_pkg::SSIO_OFF)
         begin
            // forced stop wins over everything in flight
            d.ctrl.mode = ssio_pkg::SSIO_OFF;
            d.ctrl.run = 1'b0;
            if (~q.active)
            begin
               d.ctrl.edgeSel = newCtrl.edgeSel;
               d.ctrl.clkSel = newCtrl.clkSel;
               d.ctrl.bitOrder = newCtrl.bitOrder;
            end
            d.active = 1'b0;
            d.shifting = 1'b0;
            d.txPending = 1'b0;
            d.rxDone = 1'b0;
            d.overrun = 1'b0;
            d.underrun = 1'b0;
            d.stopReq = 1'b0;
            d.bitCnt = 4'h0;
            d.launched = 1'b0;
            d.serialOut = 1'b1;
         end
         else if (~q.active)
         begin
            d.ctrl = newCtrl;
            if (newCtrl.run & (newCtrl.mode == ssio_pkg::SSIO_TX
               || newCtrl.mode == ssio_pkg::SSIO_RX))
            begin
               d.active = 1'b1;
               d.shifting = 1'b1;
               d.bitCnt = 4'h0;
               d.launched = 1'b0;
               d.stopReq = 1'b0;
               d.divCnt = 9'h000;
               if (newCtrl.mode == ssio_pkg::SSIO_TX)
               begin
                  d.shReg = q.dataBuf;
                  d.irq = 1'b1;
               end
            end
         end
         else if (~newCtrl.run & q.ctrl.run)
         begin
            // only run clear or mode 00 is honoured while active
            d.ctrl.run = 1'b0;
            if (~d.shifting & d.active)
            begin
               d.active = 1'b0;
               d.txPending = 1'b0;
               d.irq = txMode;
               if (txMode & ~extClk)
                  d.serialOut = 1'b1;
            end
            else if (d.active)
               d.stopReq = 1'b1;
         end
      end

      // data buffer write
      if (wrBuf)
      begin
         d.dataBuf = hwdata[7:0];
         if (txMode & d.active & ~d.stopReq)
         begin
            if (~d.shifting)
            begin
               d.shReg = hwdata[7:0];
               d.shifting = 1'b1;
               d.bitCnt = 4'h0;
               d.launched = 1'b0;
               d.irq = 1'b1;
            end
            else
               d.txPending = 1'b1;
         end
      end

      // internal clock parks at idle level whenever not shifting
      if (~d.active | ~d.shifting | (d.ctrl.clkSel == `SSIO_CKS_EXT))
      begin
         d.sclk = ~d.ctrl.edgeSel;
         d.divCnt = 9'h000;
      end
   end

   // ***************************************************************
   // state register
   // ***************************************************************

   // synchronous reset, every field to a constant
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         q <= '0;
         q.ctrl <= ssio_pkg::ssio_ctrl_t'(`SSIO_CTRL_RST);
         q.sclk <= 1'b1;
         q.serialOut <= 1'b1;
      end
      else
         q <= d;
   end

   // outputs; bus never waits and always answers okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign serialClockOut = q.sclk;
   assign serialClockOe = ~extClk & (q.ctrl.mode != ssio_pkg::SSIO_OFF);
   assign serialOut = q.serialOut;
   assign serialIrq = q.irq;

   // ***************************************************************
   // assertions
   // ***************************************************************

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_txStart;
      wrCtrl && !q.active && newCtrl.run && newCtrl.mode == ssio_pkg::SSIO_TX;
   endsequence

   sequence s_startSeen;
      q.active && q.shifting && serialIrq && q.shReg == $past(q.dataBuf);
   endsequence

   property p_txStart;
      s_txStart |=> s_startSeen;
   endproperty
   a_txStart: assert property (p_txStart) else $error("tx start bad");

   property p_cfgLock;
      wrCtrl && q.active |=> $stable(q.ctrl.clkSel) && $stable(q.ctrl.edgeSel)
         && $stable(q.ctrl.bitOrder);
   endproperty
   a_cfgLock: assert property (p_cfgLock) else $error("config changed");

   property p_abort;
      wrCtrl && newCtrl.mode == ssio_pkg::SSIO_OFF |=> statusImg == `SSIO_STAT_RST
         && serialOut && !q.ctrl.run;
   endproperty
   a_abort: assert property (p_abort) else $error("abort incomplete");

   property p_extNoDrive;
      q.ctrl.clkSel == `SSIO_CKS_EXT |-> !serialClockOe;
   endproperty
   a_extNoDrive: assert property (p_extNoDrive) else $error("ext clock driven");

   // a same-cycle forced stop or buffer write legally overrides the capture
   property p_rxDone;
      byteDone && rxMode && !q.rxDone && !wrBuf
         && !(wrCtrl && newCtrl.mode == ssio_pkg::SSIO_OFF) |=> q.rxDone && serialIrq
         && q.dataBuf == $past(d.shReg);
   endproperty
   a_rxDone: assert property (p_rxDone) else $error("rx byte lost");

   property p_overrun;
      byteDone && rxMode && q.rxDone && extClk && !wrBuf
         && !(wrCtrl && newCtrl.mode == ssio_pkg::SSIO_OFF) |=> q.overrun && $stable(q.dataBuf);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun bad");

   property p_bufRdClr;
      rdBuf && !byteDone |=> !q.rxDone;
   endproperty
   a_bufRdClr: assert property (p_bufRdClr) else $error("done not cleared");

   property p_pend;
      wrBuf && txMode && q.active && q.shifting && !q.stopReq && !byteDone
         |=> q.txPending;
   endproperty
   a_pend: assert property (p_pend) else $error("pending not set");

   property p_bitCnt;
      q.bitCnt < `SSIO_BITS;
   endproperty
   a_bitCnt: assert property (p_bitCnt) else $error("bit count overflow");

   property p_txWaitHigh;
      txMode && q.active && !q.shifting && !extClk |-> serialOut && serialClockOut
         == ~q.ctrl.edgeSel;
   endproperty
   a_txWaitHigh: assert property (p_txWaitHigh) else $error("wait not idle");

endmodule

// [test/ssio_peer.sv]
// Purpose: far-side serial device for the bench
// Assumes: the bench resolves the clock pin level
// Notes: captures data out mid-bit: 100 ns after the sample edge of its own clock,
// else 100 ns after the launch edge, since the block parks data out at the last sample
`timescale 1ns/1ns
module ssio_peer
(
   // pin levels
   input wire logic pinClk,
   input wire logic serialOut,
   // driven by the peer
   output logic extClk,
   output logic serialIn
);
   logic edgeSel = 1'b0;
   logic msbFirst = 1'b0;
   logic [7:0] txWord = 8'h00;
   logic [2:0] idx = 3'h0;
   logic [7:0] cap = 8'h00;
   int capCnt = 0;
   logic ownClk = 1'b0;
   initial extClk = 1'b1;
   initial serialIn = 1'b1;
   // set up an exchange; wait lets a stray edge from the pin switch settle
   task automatic arm(input logic [7:0] w, input logic e, input logic m);
      edgeSel = e;
      msbFirst = m;
      txWord = w;
      extClk <= ~e;
      #150;
      idx = 3'h0;
      capCnt = 0;
   endtask
   // link clock only within frames, stands at idle level otherwise
   task automatic extFrame(input int n);
      ownClk = 1'b1;
      repeat (n)
      begin
         #200 extClk <= edgeSel;
         #200 extClk <= ~edgeSel;
      end
      #400;
      ownClk = 1'b0;
   endtask
   // launch on one edge; capture after the other on its own clock, else after the launch edge
   always @(pinClk)
   begin
      if (pinClk === edgeSel)
      begin
         serialIn <= msbFirst ? txWord[3'h7 - idx] : txWord[idx];
         idx <= idx + 3'h1;
      end
      if ((pinClk === edgeSel) != ownClk)
      begin
         #100;
         cap = msbFirst ? {cap[6:0], serialOut} : {serialOut, cap[7:1]};
         capCnt++;
      end
   end
endmodule

// [test/ssio_top_tb.sv]
// Purpose: self-checking bench of the serial port
// Assumes: ssio_peer on the pins, AHB-Lite master tasks
// Notes: clock select 100 gives a 64-cycle byte, slow enough for the peer
`timescale 1ns/1ns
`include "ssio_defines.svh"
module ssio_top_tb;
   //***********************
   // signals
   //***********************
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout, hresp, clkOut, clkOe, serialOut, serialIn, serialIrq, extClk, pinClk;
   int err_count = 0;
   int compares = 0;
   int irqCount = 0;
   int cycles = 0;
   always #25 clk = ~clk;
   // wire level of the clock pin
   assign pinClk = clkOe ? clkOut : extClk;
   ssio_top DUT (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serialClockIn(pinClk),
      .serialClockOut(clkOut), .serialClockOe(clkOe), .serialOut(serialOut),
      .serialIn(serialIn), .serialIrq(serialIrq));
   ssio_peer peer (.pinClk(pinClk), .serialOut(serialOut), .extClk(extClk),
      .serialIn(serialIn));
   // irq pulses are one cycle, so count them per edge
   always @(posedge clk)
   begin
      if (serialIrq === 1'b1) irqCount <= irqCount + 1;
   end
   // hang guard
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         err_count++;
         report_and_stop();
      end
   end
   //***********************
   // tasks
   //***********************
   task automatic report_and_stop();
      $display("compares=%0d mismatches=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // address phase held until hready, then data phase
   task automatic busCycle(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
   endtask
   task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
      busCycle(a, 1'b1, d);
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask
   // data sampled in the data phase, equal to its value at the closing edge
   task automatic busRead(input logic [7:0] a, output logic [31:0] d);
      busCycle(a, 1'b0, 32'h0);
      do
      begin
         @(posedge clk);
         d = hrdata;
      end
      while (hreadyout !== 1'b1);
   endtask
   function automatic logic [31:0] ctl(input logic run, input logic e, input logic [2:0] cks,
      input logic dir, input logic [1:0] m);
      return {24'h0, run, e, cks, dir, m};
   endfunction
   task automatic waitCap(input int n);
      repeat (3000)
      begin
         if (peer.capCnt >= n) break;
         @(posedge clk);
      end
      if (peer.capCnt < n) err_count++;
   endtask
   task automatic waitRxDone();
      repeat (200)
      begin
         busRead(`SSIO_STAT_OFS, rd);
         if ((rd & 32'h10) === 32'h10) break;
      end
      if ((rd & 32'h10) !== 32'h10) err_count++;
   endtask
   //***********************
   // scenarios
   //***********************
   task automatic t_reset();
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'h0);
      busRead(8'h10, rd);
      check(rd, 32'h0);
      check({serialOut, clkOe}, 2'h2);
      check({hresp, hreadyout}, 2'h1);
      // mode 11 is stored but starts nothing
      busWrite(`SSIO_CTRL_OFS, ctl(1'b1, 1'b0, 3'h4, 1'b0, 2'h3));
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'h0);
      check(irqCount, 0);
      $display("test reset done");
   endtask
   task automatic t_tx_int();
      peer.arm(8'h00, 1'b0, 1'b0);
      busWrite(`SSIO_BUF_OFS, 32'hA5);
      busWrite(`SSIO_CTRL_OFS, ctl(1'b1, 1'b0, 3'h4, 1'b0, 2'h1));
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'hC0);
      check(irqCount, 1);
      busWrite(`SSIO_BUF_OFS, 32'h5A);
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'hC4);
      busWrite(`SSIO_CTRL_OFS, ctl(1'b1, 1'b1, 3'h2, 1'b1, 2'h1));
      busRead(`SSIO_CTRL_OFS, rd);
      check(rd, ctl(1'b1, 1'b0, 3'h4, 1'b0, 2'h1));
      waitCap(8);
      check(peer.cap, 8'hA5);
      waitCap(16);
      check(peer.cap, 8'h5A);
      check(irqCount, 2);
      repeat (20) @(posedge clk);
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'h80);
      check({serialOut, clkOut}, 2'h3);
      busWrite(`SSIO_BUF_OFS, 32'h3C);
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'hC0);
      check(irqCount, 3);
      busWrite(`SSIO_CTRL_OFS, ctl(1'b0, 1'b0, 3'h4, 1'b0, 2'h1));
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'hC0);
      waitCap(24);
      check(peer.cap, 8'h3C);
      repeat (20) @(posedge clk);
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'h0);
      check({serialOut, irqCount[3:0]}, 5'h14);
      $display("test tx internal done");
   endtask
   task automatic t_rx_int();
      peer.arm(8'h96, 1'b1, 1'b1);
      busWrite(`SSIO_CTRL_OFS, ctl(1'b1, 1'b1, 3'h4, 1'b1, 2'h2));
      waitRxDone();
      check(rd, 32'h90);
      check(irqCount, 5);
      busRead(`SSIO_BUF_OFS, rd);
      check(rd, 32'h96);
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'hC0);
      // run clear while shifting: byte finishes, then stop with irq
      busWrite(`SSIO_CTRL_OFS, ctl(1'b0, 1'b1, 3'h4, 1'b1, 2'h2));
      waitRxDone();
      check(rd, 32'h10);
      check(irqCount, 6);
      busRead(`SSIO_BUF_OFS, rd);
      check(rd, 32'h96);
      // restart, then run clear in the automatic wait: stop at once, no irq
      busWrite(`SSIO_CTRL_OFS, ctl(1'b1, 1'b1, 3'h4, 1'b1, 2'h2));
      waitRxDone();
      check(rd, 32'h90);
      busWrite(`SSIO_CTRL_OFS, ctl(1'b0, 1'b1, 3'h4, 1'b1, 2'h2));
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'h10);
      check(irqCount, 7);
      busWrite(`SSIO_CTRL_OFS, ctl(1'b0, 1'b1, 3'h4, 1'b1, 2'h0));
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'h0);
      check({serialOut, clkOe}, 2'h2);
      $display("test rx internal done");
   endtask
   task automatic t_rx_ext();
      peer.arm(8'h5A, 1'b0, 1'b0);
      busWrite(`SSIO_CTRL_OFS, ctl(1'b1, 1'b0, 3'h7, 1'b0, 2'h2));
      peer.extFrame(8);
      peer.txWord = 8'hC3;
      peer.extFrame(8);
      busRead(`SSIO_STAT_OFS, rd);
      check(rd & 32'h30, 32'h30);
      check(irqCount, 9);
      busRead(`SSIO_STAT_OFS, rd);
      check(rd & 32'h30, 32'h10);
      busRead(`SSIO_BUF_OFS, rd);
      check(rd, 32'h5A);
      busRead(`SSIO_STAT_OFS, rd);
      check(rd & 32'h10, 32'h0);
      busWrite(`SSIO_CTRL_OFS, ctl(1'b0, 1'b0, 3'h7, 1'b0, 2'h0));
      $display("test rx external done");
   endtask
   task automatic t_tx_ext();
      peer.arm(8'h00, 1'b0, 1'b0);
      busWrite(`SSIO_BUF_OFS, 32'h01);
      busWrite(`SSIO_CTRL_OFS, ctl(1'b1, 1'b0, 3'h7, 1'b0, 2'h1));
      peer.extFrame(8);
      check(peer.cap, 8'h01);
      check(serialOut, 1'b0);
      busRead(`SSIO_STAT_OFS, rd);
      check(rd & 32'h48, 32'h0);
      // idle between bytes: run clear stops at once, output keeps its level
      busWrite(`SSIO_CTRL_OFS, ctl(1'b0, 1'b0, 3'h7, 1'b0, 2'h1));
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'h0);
      check({serialOut, irqCount[3:0]}, 5'h0B);
      busWrite(`SSIO_CTRL_OFS, ctl(1'b1, 1'b0, 3'h7, 1'b0, 2'h1));
      peer.extFrame(8);
      peer.extFrame(1);
      busRead(`SSIO_STAT_OFS, rd);
      check(rd & 32'h08, 32'h08);
      // junk byte under way: end with mode 00, no buffer write
      busWrite(`SSIO_CTRL_OFS, ctl(1'b0, 1'b0, 3'h7, 1'b0, 2'h0));
      busRead(`SSIO_STAT_OFS, rd);
      check(rd, 32'h0);
      check(serialOut, 1'b1);
      check(irqCount, 12);
      $display("test tx external done");
   endtask
   //***********************
   // main sequence
   //***********************
   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_tx_int();
      t_rx_int();
      t_rx_ext();
      t_tx_ext();
      report_and_stop();
   end
endmodule
